// file: hdl/wdt_pwr_pkg.sv
// Package: register map, field positions and timing for the watchdog and power control
// Function
// - Unscaled watchdog times out after about 18 ms of its own oscillator.
// - Option register assigns shared prescaler to watchdog, ratios up to 1:128.
// - Clear-watchdog or sleep instruction clears counter and assigned prescaler.
// - Watchdog timeout generates a device reset.
// - Timeout clears the active-low timeout flag in status.
// - Measured unscaled watchdog period readable at calibration word 0FD2h.
// - Clear-watchdog opcode 00 0000 0110 0100 zeroes counter, sets both flags.
// - CPU clock stopped in sleep or hibernate, running otherwise.
// - Main oscillator runs unless sleeping with oscillator-off bit 3 set.
// - Watchdog gated by config enable bit and hibernate select bit 7.
// - Temperature-off bit 1 powers down the temperature sensor.
// - Reference-off bit 5 powers down low-voltage detector and bandgap.
// - Comparator-off bit 2 powers down comparators and programmable references.
// - Converter-off bit 0 gates converter parts; current source also by config 7:4.
// - Level-shift-off bit 4 powers down level shift networks.
// - Power-on reset active except in sleep or hibernate.
// - Converter may keep running during sleep when its gating allows.
// - Power gating bits live in sleep control register at 8Fh.
package wdt_pwr_pkg;
   // ----------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------
   localparam logic [7:0] SLEEP_POWER_GATING_IDX = 8'h8f;
   localparam logic [9:0] SLEEP_POWER_GATING_ADDR = {SLEEP_POWER_GATING_IDX, 2'b00};
   localparam logic [9:0] OPTION_ADDR = 10'h000;
   localparam logic [9:0] STATUS_ADDR = 10'h004;
   localparam logic [9:0] CONV_CFG_ADDR = 10'h008;
   localparam logic [9:0] IRQ_STAT_ADDR = 10'h00c;
   localparam logic [9:0] IRQ_MASK_ADDR = 10'h010;
   localparam logic [9:0] CMD_ADDR = 10'h014;
   localparam logic [9:0] CAL_ADDR = 10'h018;
   localparam logic [11:0] CAL_WORD_ADDR = 12'hfd2;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CONVERTER_OFF_BIT = 0;
   localparam int TEMP_SENSOR_OFF_BIT = 1;
   localparam int COMPARATOR_OFF_BIT = 2;
   localparam int MAIN_OSC_SLEEP_OFF_BIT = 3;
   localparam int LEVEL_SHIFT_OFF_BIT = 4;
   localparam int REFERENCE_OFF_BIT = 5;
   localparam int HIBERNATE_SELECT_BIT = 7;
   localparam int CFG_WDT_ENABLE_BIT = 2;
   localparam int OPT_PSA_BIT = 3;
   localparam int OPT_PS_LSB = 0;
   localparam int STAT_TIMEOUT_BIT = 4;
   localparam int STAT_POWERDOWN_BIT = 3;
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int CMD_WATCHDOG_CLEAR_INSTR_BIT = 0;
   localparam int CMD_SLEEP_BIT = 1;
   localparam int CMD_WAKE_BIT = 2;
   // ----------------------------------------
   // Reset values and encodings
   // ----------------------------------------
   localparam logic [7:0] SLEEP_POWER_GATING_RST = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] CONV_CFG_RST = 8'h00;
   localparam logic [13:0] WATCHDOG_CLEAR_INSTR_OPCODE = 14'h0064;
   localparam logic [13:0] SLEEP_OPCODE = 14'h0063;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int WDT_PERIOD_MS = 18;
   localparam longint WDT_PERIOD_CYCLES = longint'(WDT_PERIOD_MS) * CLK_MHZ * 1000;
   localparam int RESET_PULSE_CYCLES = 4;
endpackage

// file: hdl/wdt_pwr_ctrl.sv
// Watchdog timer with shared prescaler and sleep power gating, Wishbone slave
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module wdt_pwr_ctrl
   import wdt_pwr_pkg::*;
#(
   parameter longint WDT_CYCLES = WDT_PERIOD_CYCLES,
   parameter logic [15:0] WDT_CAL_VALUE = 16'h0012
)
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SRST,
   // Wishbone slave
   input wire logic I_CYC,
   input wire logic I_STB,
   input wire logic I_WE,
   input wire logic [3:0] I_SEL,
   input wire logic [9:0] I_ADR,
   input wire logic [31:0] I_DAT,
   output logic [31:0] O_DAT,
   output logic O_ACK,
   // Instruction decode and configuration
   input wire logic I_INSTR_VALID,
   input wire logic [13:0] I_INSTR,
   input wire logic I_WAKE,
   input wire logic [13:0] I_CONFIG_WORD,
   input wire logic I_WDT_OSC_TICK,
   // Power, reset and interrupt outputs
   output logic O_DEVICE_RESET,
   output logic O_CPU_CLK_EN,
   output logic O_MAIN_OSC_EN,
   output logic O_WDT_RUN,
   output logic O_TEMP_SENSOR_EN,
   output logic O_REFERENCE_EN,
   output logic O_COMPARATOR_EN,
   output logic O_CONVERTER_EN,
   output logic O_CURRENT_SRC_EN,
   output logic O_LEVEL_SHIFT_EN,
   output logic O_POR_EN,
   output logic O_IRQ
);
   localparam int CW = $clog2(WDT_CYCLES + 1);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   // Counter must step at least once before the terminal compare
   if (WDT_CYCLES < 2)
   begin : g_short_period
      $error("WDT_CYCLES must be at least 2");
   end
   // Pulse counter is three bits wide
   if (RESET_PULSE_CYCLES < 1 || RESET_PULSE_CYCLES > 7)
   begin : g_bad_pulse
      $error("RESET_PULSE_CYCLES out of range");
   end

   typedef enum logic [1:0] {RUN_S = 2'b00, SLEEP_S = 2'b01, HIB_S = 2'b11} pmode_t;

   function automatic logic [6:0] ps_limit(input logic [2:0] sel);
      ps_limit = 7'(({7'h00, 1'b1} << sel) - 8'h01);
   endfunction

   // Write strobe decode shared by the registers and the command word
   function automatic logic wr_at(input logic w, input logic [9:0] adr, input logic [9:0] a);
      wr_at = w && adr == a;
   endfunction

   pmode_t mode_reg;
   logic [7:0] spg_reg;
   logic [7:0] opt_reg;
   logic [7:0] cfg_reg;
   logic timeout_flag_n_reg;
   logic powerdown_flag_n_reg;
   logic [CW-1:0] watchdog_counter_reg;
   logic [6:0] ps_reg;
   logic [2:0] rst_cnt_reg;
   logic irq_stat_reg;
   logic irq_mask_reg;
   logic [31:0] rd_next;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire logic bus_req = I_CYC && I_STB && !O_ACK;
   wire logic wr = bus_req && I_WE && I_SEL[0];
   wire logic watchdog_clear_instr = I_INSTR_VALID && (I_INSTR == WATCHDOG_CLEAR_INSTR_OPCODE)
      || wr_at(wr, I_ADR, CMD_ADDR) && I_DAT[CMD_WATCHDOG_CLEAR_INSTR_BIT];
   wire logic sleep_cmd = I_INSTR_VALID && (I_INSTR == SLEEP_OPCODE)
      || wr_at(wr, I_ADR, CMD_ADDR) && I_DAT[CMD_SLEEP_BIT];
   wire logic wake = I_WAKE || wr_at(wr, I_ADR, CMD_ADDR) && I_DAT[CMD_WAKE_BIT];
   wire logic sleeping = mode_reg != RUN_S;
   // Hibernate turns the watchdog off even when configured on
   wire logic wdt_en = I_CONFIG_WORD[CFG_WDT_ENABLE_BIT] && !(sleeping
      && spg_reg[HIBERNATE_SELECT_BIT]);
   wire logic ps_wdt = opt_reg[OPT_PSA_BIT];
   wire logic ps_wrap = !ps_wdt || ps_reg >= ps_limit(opt_reg[OPT_PS_LSB +: 3]);
   wire logic timeout = wdt_en && I_WDT_OSC_TICK && ps_wrap
      && watchdog_counter_reg >= CW'(WDT_CYCLES - 1);
   wire logic restart = watchdog_clear_instr || sleep_cmd || rst_cnt_reg != 3'd0;

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_ACK <= 1'b0;
      else
         O_ACK <= bus_req;
   end

   always_comb
   begin
      rd_next = 32'h0;
      unique case (I_ADR)
         SLEEP_POWER_GATING_ADDR: rd_next = {24'h0, spg_reg};
         OPTION_ADDR: rd_next = {24'h0, opt_reg};
         STATUS_ADDR:
         begin
            rd_next[STAT_TIMEOUT_BIT] = timeout_flag_n_reg;
            rd_next[STAT_POWERDOWN_BIT] = powerdown_flag_n_reg;
         end
         CONV_CFG_ADDR: rd_next = {24'h0, cfg_reg};
         IRQ_STAT_ADDR: rd_next = {31'h0, irq_stat_reg};
         IRQ_MASK_ADDR: rd_next = {31'h0, irq_mask_reg};
         CAL_ADDR: rd_next = {4'h0, CAL_WORD_ADDR, WDT_CAL_VALUE};
         default: rd_next = 32'h0;
      endcase
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_DAT <= 32'h0;
      else if (bus_req && !I_WE)
         O_DAT <= rd_next;
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         spg_reg <= SLEEP_POWER_GATING_RST;
      else if (wr_at(wr, I_ADR, SLEEP_POWER_GATING_ADDR))
         spg_reg <= I_DAT[7:0];
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         opt_reg <= OPTION_RST;
      else if (wr_at(wr, I_ADR, OPTION_ADDR))
         opt_reg <= I_DAT[7:0];
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         cfg_reg <= CONV_CFG_RST;
      else if (wr_at(wr, I_ADR, CONV_CFG_ADDR))
         cfg_reg <= I_DAT[7:0];
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         irq_mask_reg <= 1'b0;
      else if (wr_at(wr, I_ADR, IRQ_MASK_ADDR))
         irq_mask_reg <= I_DAT[IRQ_TIMEOUT_BIT];
   end

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   // Timeout sets win over a write-one clear
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         irq_stat_reg <= 1'b0;
      else if (timeout)
         irq_stat_reg <= 1'b1;
      else if (wr_at(wr, I_ADR, IRQ_STAT_ADDR) && I_DAT[IRQ_TIMEOUT_BIT])
         irq_stat_reg <= 1'b0;
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_IRQ <= 1'b0;
      else
         O_IRQ <= irq_stat_reg && irq_mask_reg;
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   // Flags survive the watchdog reset so software can read the cause
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         timeout_flag_n_reg <= 1'b1;
         powerdown_flag_n_reg <= 1'b1;
      end
      else if (timeout)
         timeout_flag_n_reg <= 1'b0;
      else if (watchdog_clear_instr)
      begin
         timeout_flag_n_reg <= 1'b1;
         powerdown_flag_n_reg <= 1'b1;
      end
      else if (sleep_cmd)
      begin
         timeout_flag_n_reg <= 1'b1;
         powerdown_flag_n_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Watchdog counter and prescaler
   // ----------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST || restart)
         ps_reg <= 7'h00;
      else if (wdt_en && I_WDT_OSC_TICK)
         ps_reg <= ps_wrap ? 7'h00 : 7'(ps_reg + 7'h01);
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST || restart)
         watchdog_counter_reg <= '0;
      else if (wdt_en && I_WDT_OSC_TICK && ps_wrap)
         watchdog_counter_reg <= timeout ? '0 : CW'(watchdog_counter_reg + 1'b1);
   end

   // ----------------------------------------
   // Device reset
   // ----------------------------------------
   // Stretched pulse so slow reset domains see it
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         rst_cnt_reg <= 3'd0;
      else if (timeout)
         rst_cnt_reg <= 3'(RESET_PULSE_CYCLES);
      else if (rst_cnt_reg != 3'd0)
         rst_cnt_reg <= rst_cnt_reg - 3'd1;
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_DEVICE_RESET <= 1'b0;
      else
         O_DEVICE_RESET <= timeout || rst_cnt_reg > 3'd1;
   end

   // ----------------------------------------
   // Power mode
   // ----------------------------------------
   // Mode is chosen at sleep entry; the watchdog gate follows bit 7 live
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST || rst_cnt_reg != 3'd0)
         mode_reg <= RUN_S;
      else
         unique case (mode_reg)
            RUN_S:
               if (sleep_cmd)
                  mode_reg <= spg_reg[HIBERNATE_SELECT_BIT] ? HIB_S : SLEEP_S;
            SLEEP_S, HIB_S:
               if (wake || timeout)
                  mode_reg <= RUN_S;
            default: mode_reg <= RUN_S;
         endcase
   end

   // ----------------------------------------
   // Clock, oscillator and watchdog gating
   // ----------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_CPU_CLK_EN <= 1'b1;
         O_POR_EN <= 1'b1;
      end
      else
      begin
         O_CPU_CLK_EN <= !sleeping;
         O_POR_EN <= !sleeping;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_MAIN_OSC_EN <= 1'b1;
      else
         O_MAIN_OSC_EN <= !sleeping || !spg_reg[MAIN_OSC_SLEEP_OFF_BIT];
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
         O_WDT_RUN <= 1'b0;
      else
         O_WDT_RUN <= wdt_en;
   end

   // ----------------------------------------
   // Analog gating
   // ----------------------------------------
   // Bits act in every mode, so software may gate blocks while awake
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_TEMP_SENSOR_EN <= 1'b1;
         O_REFERENCE_EN <= 1'b1;
         O_COMPARATOR_EN <= 1'b1;
         O_LEVEL_SHIFT_EN <= 1'b1;
      end
      else
      begin
         O_TEMP_SENSOR_EN <= !spg_reg[TEMP_SENSOR_OFF_BIT];
         O_REFERENCE_EN <= !spg_reg[REFERENCE_OFF_BIT];
         O_COMPARATOR_EN <= !spg_reg[COMPARATOR_OFF_BIT];
         O_LEVEL_SHIFT_EN <= !spg_reg[LEVEL_SHIFT_OFF_BIT];
      end
   end

   // Independent of sleep state so conversions continue while halted
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_CONVERTER_EN <= 1'b1;
         O_CURRENT_SRC_EN <= 1'b0;
      end
      else
      begin
         O_CONVERTER_EN <= !spg_reg[CONVERTER_OFF_BIT];
         O_CURRENT_SRC_EN <= !spg_reg[CONVERTER_OFF_BIT] && cfg_reg[7:4] != 4'h0;
      end
   end
endmodule // wdt_pwr_ctrl

// file: tb/wdt_pwr_ctrl_assertions.sv
// Checker: port-level properties of the watchdog and power control block
`timescale 1ns/1ps
module wdt_pwr_ctrl_assertions
   import wdt_pwr_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SRST,
   // Bus and configuration
   input wire logic I_CYC,
   input wire logic I_STB,
   input wire logic O_ACK,
   input wire logic [13:0] I_CONFIG_WORD,
   // Power and reset outputs
   input wire logic O_DEVICE_RESET,
   input wire logic O_CPU_CLK_EN,
   input wire logic O_POR_EN,
   input wire logic O_MAIN_OSC_EN,
   input wire logic O_WDT_RUN,
   input wire logic O_CONVERTER_EN,
   input wire logic O_CURRENT_SRC_EN
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SRST);
   sequence s_req;
      I_CYC && I_STB && !O_ACK;
   endsequence
   // Pulse length is fixed at four cycles
   sequence s_pulse;
      O_DEVICE_RESET [*4] ##1 !O_DEVICE_RESET;
   endsequence
   a_ack_one_wait: assert property (s_req |=> O_ACK)
      else $error("bus answer not one cycle after request");
   a_ack_single: assert property (O_ACK |=> !O_ACK)
      else $error("bus answer longer than one cycle");
   a_reset_pulse_len: assert property ($rose(O_DEVICE_RESET) |-> s_pulse)
      else $error("device reset pulse length wrong");
   a_run_after_timeout: assert property ($rose(O_DEVICE_RESET) |-> ##[0:2] O_CPU_CLK_EN)
      else $error("cpu clock not running after timeout");
   a_cpu_por_pair: assert property (O_CPU_CLK_EN == O_POR_EN)
      else $error("cpu clock and power-on reset disagree");
   a_osc_when_awake: assert property (O_CPU_CLK_EN |-> O_MAIN_OSC_EN)
      else $error("main oscillator off while awake");
   a_wdt_cfg_off: assert property (
      !I_CONFIG_WORD[CFG_WDT_ENABLE_BIT] [*3] |-> !O_WDT_RUN)
      else $error("watchdog runs while disabled");
   a_isrc_gated: assert property (O_CURRENT_SRC_EN |-> O_CONVERTER_EN)
      else $error("current source on with converter off");
endmodule // wdt_pwr_ctrl_assertions

bind wdt_pwr_ctrl wdt_pwr_ctrl_assertions chk_u (.I_CLK(I_CLK), .I_SRST(I_SRST),
   .I_CYC(I_CYC), .I_STB(I_STB), .O_ACK(O_ACK), .I_CONFIG_WORD(I_CONFIG_WORD),
   .O_DEVICE_RESET(O_DEVICE_RESET), .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_POR_EN(O_POR_EN),
   .O_MAIN_OSC_EN(O_MAIN_OSC_EN), .O_WDT_RUN(O_WDT_RUN),
   .O_CONVERTER_EN(O_CONVERTER_EN), .O_CURRENT_SRC_EN(O_CURRENT_SRC_EN));

// file: tb/watchdog_power_control_tb_top.sv
// Testbench: self-checking run of the watchdog and power control block
`timescale 1ns/1ps
module watchdog_power_control_tb_top import wdt_pwr_pkg::*;;
   // Short count keeps prescaler sweeps fast
   localparam int WDT_N = 8;
   localparam logic [15:0] CAL_V = 16'h5a3c; // Arbitrary calibration value
   logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic iv = 1'b0, wake = 1'b0, tk = 1'b0;
   logic [3:0] sel = 4'hf;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [13:0] op = 14'h0, cfg_w = 14'h0004;
   logic ack, dres, cpu, osc, wrun, temp, ref_en, cmp, conv, isrc, ls, por, irq;
   int n_mismatch = 0, comparisons = 0, cycles = 0;
   int mdl [int];
   always #2 clk = ~clk;
   wdt_pwr_ctrl #(.WDT_CYCLES(WDT_N), .WDT_CAL_VALUE(CAL_V)) dut_u (
      .I_CLK(clk), .I_SRST(srst), .I_CYC(cyc), .I_STB(stb), .I_WE(we), .I_SEL(sel),
      .I_ADR(adr), .I_DAT(wdat), .O_DAT(rdat), .O_ACK(ack), .I_INSTR_VALID(iv),
      .I_INSTR(op), .I_WAKE(wake), .I_CONFIG_WORD(cfg_w), .I_WDT_OSC_TICK(tk),
      .O_DEVICE_RESET(dres), .O_CPU_CLK_EN(cpu), .O_MAIN_OSC_EN(osc), .O_WDT_RUN(wrun),
      .O_TEMP_SENSOR_EN(temp), .O_REFERENCE_EN(ref_en), .O_COMPARATOR_EN(cmp),
      .O_CONVERTER_EN(conv), .O_CURRENT_SRC_EN(isrc), .O_LEVEL_SHIFT_EN(ls),
      .O_POR_EN(por), .O_IRQ(irq));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Classic cycle; model follows only writes that the slave stores
   task automatic wb(input logic w, input logic [3:0] s, input logic [9:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ack !== 1'b1 && k < 40);
      if (k >= 40)
      begin
         chk(0, 1, "no bus answer");
         summarize;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (w && s[0] && mdl.exists(a)) mdl[a] = d & 32'hff;
   endtask
   task automatic rdm(input logic [9:0] a);
      wb(1'b0, 4'hf, a, 32'h0);
      chk(q, mdl.exists(a) ? mdl[a] : 0, "register read");
   endtask
   task automatic stchk(input int t, input int p);
      wb(1'b0, 4'hf, STATUS_ADDR, 32'h0);
      chk(q, (t << STAT_TIMEOUT_BIT) | (p << STAT_POWERDOWN_BIT), "status");
   endtask
   task automatic pwr(input bit sl);
      logic [7:0] g, c;
      logic [8:0] e;
      g = 8'(mdl[SLEEP_POWER_GATING_ADDR]);
      c = 8'(mdl[CONV_CFG_ADDR]);
      e = {!g[1], !g[5], !g[2], !g[0], !g[0] && c[7:4] != 0, !g[4], !(sl && g[3]), !sl, !sl};
      repeat (3) @(posedge clk);
      chk({temp, ref_en, cmp, conv, isrc, ls, osc, cpu, por}, e, "power");
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         tk <= 1'b1;
         @(posedge clk);
         tk <= 1'b0;
      end
   endtask
   task automatic instr(input logic [13:0] o);
      @(posedge clk);
      iv <= 1'b1;
      op <= o;
      @(posedge clk);
      iv <= 1'b0;
   endtask
   task automatic wk;
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
   endtask
   // No reset one tick early, then reset or silence on the last tick
   task automatic tmo(input int n, input logic e);
      tick(n - 1);
      repeat (2) @(posedge clk);
      chk(dres, 0, "early reset");
      tick(1);
      repeat (2) @(posedge clk);
      chk(dres, e, "timeout reset");
      repeat (8) @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         n_mismatch++;
         summarize;
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'hf61e));
      mdl[OPTION_ADDR] = OPTION_RST;
      mdl[SLEEP_POWER_GATING_ADDR] = SLEEP_POWER_GATING_RST;
      mdl[CONV_CFG_ADDR] = CONV_CFG_RST;
      mdl[IRQ_MASK_ADDR] = 0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      foreach (mdl[a]) rdm(10'(a));
      stchk(1, 1);
      wb(1'b0, 4'hf, CAL_ADDR, 32'h0);
      chk(q, {4'h0, CAL_WORD_ADDR, CAL_V}, "calibration");
      wb(1'b1, 4'hf, 10'h3fc, 32'hff);
      rdm(10'h3fc);
      wb(1'b1, 4'he, SLEEP_POWER_GATING_ADDR, 32'hff);
      rdm(SLEEP_POWER_GATING_ADDR);
      pwr(0);
      for (int b = 0; b < 12; b++)
      begin
         wb(1'b1, 4'hf, CONV_CFG_ADDR, $urandom);
         wb(1'b1, 4'hf, SLEEP_POWER_GATING_ADDR, b < 8 ? 32'h1 << b : $urandom);
         rdm(SLEEP_POWER_GATING_ADDR);
         pwr(0);
      end
      wb(1'b1, 4'hf, SLEEP_POWER_GATING_ADDR, 32'h0);
      wb(1'b1, 4'hf, OPTION_ADDR, 32'h0);
      chk(wrun, 1, "watchdog running");
      tmo(WDT_N, 1);
      stchk(0, 1);
      chk(irq, 0, "masked interrupt");
      wb(1'b1, 4'hf, IRQ_MASK_ADDR, 32'h1 << IRQ_TIMEOUT_BIT);
      @(posedge clk);
      chk(irq, 1, "interrupt raised");
      wb(1'b0, 4'hf, IRQ_STAT_ADDR, 32'h0);
      chk(q, 32'h1 << IRQ_TIMEOUT_BIT, "interrupt status");
      wb(1'b1, 4'hf, IRQ_STAT_ADDR, 32'h1 << IRQ_TIMEOUT_BIT);
      repeat (2) @(posedge clk);
      chk(irq, 0, "interrupt cleared");
      tick(WDT_N - 1);
      instr(WATCHDOG_CLEAR_INSTR_OPCODE);
      stchk(1, 1);
      tmo(WDT_N, 1);
      tick(WDT_N - 1);
      wb(1'b1, 4'hf, CMD_ADDR, 32'h1 << CMD_WATCHDOG_CLEAR_INSTR_BIT);
      tmo(WDT_N, 1);
      for (int ps = 0; ps < 8; ps++)
      begin
         wb(1'b1, 4'hf, OPTION_ADDR, (32'h1 << OPT_PSA_BIT) | ps);
         tick(3);
         instr(WATCHDOG_CLEAR_INSTR_OPCODE);
         tmo(WDT_N << ps, 1);
      end
      wb(1'b1, 4'hf, OPTION_ADDR, 32'h0);
      // Sleep clears the count; watchdog keeps going while asleep
      tick(WDT_N - 1);
      instr(SLEEP_OPCODE);
      pwr(1);
      stchk(1, 0);
      tmo(WDT_N, 1);
      pwr(0);
      wb(1'b1, 4'hf, SLEEP_POWER_GATING_ADDR, 32'h1 << MAIN_OSC_SLEEP_OFF_BIT);
      wb(1'b1, 4'hf, CMD_ADDR, 32'h1 << CMD_SLEEP_BIT);
      pwr(1);
      wk;
      pwr(0);
      wb(1'b1, 4'hf, CMD_ADDR, 32'h1 << CMD_SLEEP_BIT);
      pwr(1);
      wb(1'b1, 4'hf, CMD_ADDR, 32'h1 << CMD_WAKE_BIT);
      pwr(0);
      wb(1'b1, 4'hf, SLEEP_POWER_GATING_ADDR, 32'h1 << HIBERNATE_SELECT_BIT);
      instr(SLEEP_OPCODE);
      pwr(1);
      chk(wrun, 0, "hibernate stops watchdog");
      tmo(WDT_N, 0);
      wk;
      pwr(0);
      cfg_w <= 14'h0;
      repeat (4) @(posedge clk);
      chk(wrun, 0, "config disables watchdog");
      tmo(WDT_N, 0);
      summarize;
   end
endmodule // watchdog_power_control_tb_top
